// ===== inc/mrtm_map.svh
// register indices, field positions and constant values of the range type map
// assumes: included by bare name from the design files
`ifndef MRTM_MAP_SVH
`define MRTM_MAP_SVH

// ------------------------------------------------------------
// model-register indices
// ------------------------------------------------------------
`define MRTM_IDX_DEF      8'h00
`define MRTM_IDX_FIX_LO   8'h01
`define MRTM_IDX_FIX_HI   8'h0B
`define MRTM_IDX_VAR_LO   8'h0C
`define MRTM_IDX_CAP      8'h20
`define MRTM_WORDS        28
`define MRTM_LAST_WORD    8'h1B

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MRTM_DEF_FE_BIT   10
`define MRTM_DEF_E_BIT    11
`define MRTM_MASK_V_BIT   11
`define MRTM_FEAT_RT_BIT  12

// ------------------------------------------------------------
// reserved-bit masks and constant values
// ------------------------------------------------------------
`define MRTM_DEF_RSVD     64'hFFFF_FFFF_FFFF_F300
`define MRTM_BASE_RSVD    64'hFFFF_FFF0_0000_0F00
`define MRTM_MASK_RSVD    64'hFFFF_FFF0_0000_07FF
`define MRTM_CAP_VALUE    64'h0000_0000_0000_0508
`define MRTM_FEAT_VALUE   32'h0000_1000
`define MRTM_WORD_RST     64'h0000_0000_0000_0000

`endif

// ===== inc/mrtm_pkg.sv
// types shared by the range type map design files
// assumes: mrtm_map.svh is on the include path
package mrtm_pkg;

  // memory type encodings of one 8-bit type field
  typedef enum logic [7:0] {
    mt_uncacheable     = 8'h00,
    mt_write_combining = 8'h01,
    mt_write_through   = 8'h04,
    mt_write_protected = 8'h05,
    mt_writeback       = 8'h06
  } mrtm_mem_type_t;

  // one model-register access from privileged software
  typedef struct packed {
    logic        wr;     // 1 write, 0 read
    logic [7:0]  idx;    // register index
    logic [63:0] wdata;  // write data
  } mrtm_msr_req_t;

  // access state machine
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_read = 2'b10
  } mrtm_state_t;

endpackage

// ===== hw/mrtm_regfile.sv
// storage of the default-type, fixed-range and variable-range words
// assumes: writer checks index and data before raising wr_en_i
`timescale 1ns/1ps
`include "mrtm_map.svh"

module mrtm_regfile (
  input  wire logic                    clk_sys_i,  // core clock
  input  wire logic                    rst_n_i,    // sync reset, low
  input  wire logic                    wr_en_i,    // write strobe
  input  wire logic [4:0]              wr_idx_i,   // write word index
  input  wire logic [63:0]             wr_data_i,  // write data
  input  wire logic                    rd_en_i,    // read strobe
  input  wire logic [4:0]              rd_idx_i,   // read word index
  output logic      [63:0]             rd_data_o,  // registered read data
  output logic      [`MRTM_WORDS-1:0][63:0] words_o  // all words for lookup
);

  logic [`MRTM_WORDS-1:0][63:0] mem_ff;
  logic [`MRTM_WORDS-1:0][63:0] nxt_mem;
  logic [63:0]                  rdata_ff;
  logic [63:0]                  nxt_rdata;

  // next word contents and read data
  always_comb begin
    nxt_mem   = mem_ff;
    nxt_rdata = rdata_ff;
    if (wr_en_i) begin
      nxt_mem[wr_idx_i] = wr_data_i;
    end
    if (rd_en_i) begin
      nxt_rdata = mem_ff[rd_idx_i];
    end
  end

  // every word clears, so all ranges start disabled
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mem_ff   <= {`MRTM_WORDS{`MRTM_WORD_RST}};
      rdata_ff <= `MRTM_WORD_RST;
    end else begin
      mem_ff   <= nxt_mem;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rd_data_o = rdata_ff;
  assign words_o   = mem_ff;

endmodule

// ===== hw/mrtm_lookup.sv
// combinational memory type lookup for one physical address
// assumes: 36-bit physical address, words laid out as in mrtm_map.svh
`timescale 1ns/1ps
`include "mrtm_map.svh"

module mrtm_lookup (
  input  wire logic [35:0]                  addr_i,     // physical address
  input  wire logic [`MRTM_WORDS-1:0][63:0] words_i,    // register words
  output logic      [7:0]                   type_o,     // resolved type
  output logic                              fix_hit_o   // fixed field used
);

  logic [63:0] def_w;
  logic [4:0]  fidx;
  logic [2:0]  fbyte;
  logic [7:0]  fix_type;
  logic [63:0] base_w;
  logic [63:0] mask_w;

  // fixed field select: 64K below 80000H, 16K to BFFFFH, 4K to FFFFFH
  always_comb begin
    fidx  = 5'h01;
    fbyte = addr_i[18:16];
    if (addr_i[19] && !addr_i[18]) begin
      fidx  = 5'(2 + addr_i[17]);
      fbyte = addr_i[16:14];
    end else if (addr_i[19]) begin
      fidx  = 5'(4 + addr_i[17:15]);
      fbyte = addr_i[14:12];
    end
    fix_type = words_i[fidx][{fbyte, 3'b000} +: 8];
  end

  // resolve: master off gives uncacheable, fixed beats variable
  always_comb begin
    def_w     = words_i[0];
    base_w    = '0;
    mask_w    = '0;
    type_o    = mrtm_pkg::mt_uncacheable;
    fix_hit_o = 1'b0;
    if (def_w[`MRTM_DEF_E_BIT]) begin
      type_o = def_w[7:0];
      // descending walk so the lowest matching pair wins an overlap
      for (int n = 7; n >= 0; n--) begin
        base_w = words_i[12 + 2 * n];
        mask_w = words_i[13 + 2 * n];
        if (mask_w[`MRTM_MASK_V_BIT] &&
            ((addr_i[35:12] & mask_w[35:12]) == (base_w[35:12] & mask_w[35:12]))) begin
          type_o = base_w[7:0];
        end
      end
      if (def_w[`MRTM_DEF_FE_BIT] && (addr_i[35:20] == 16'h0000)) begin
        type_o    = fix_type;
        fix_hit_o = 1'b1;
      end
    end
  end

endmodule

// ===== hw/mrtm_top.sv
// memory range type map: model-register access port and type lookup
// assumes: one requester, holds its request until ready_o is seen high
//
// Behaviour
// - up to 96 ranges: 88 fixed, 8 variable
// - reset disables all fixed and variable ranges
// - type codes 00,01,04,05,06 are legal
// - reserved type code written raises protection fault
// - no cross-processor sync of range contents
// - feature query bit 12 reports range registers
// - 64-bit read-only capability register, model-register read
// - capability bits 0-7 give eight variable ranges
// - capability bit 8 says fixed ranges exist
// - capability bit 10 says write combining supported
// - capability write raises protection fault
// - capability always reads 508H
// - range register write flushes every translation entry
// - master enable clear makes everything uncacheable
// - fixed range type beats variable range type
// - variable hit: masked address equals masked base
`timescale 1ns/1ps
`include "mrtm_map.svh"

module mrtm_top (
  input  wire logic        clk_sys_i,    // core clock, 250 MHz
  input  wire logic        rst_n_i,      // sync reset, low
  input  wire logic        req_i,        // model-register access request
  input  wire logic        req_wr_i,     // 1 write, 0 read
  input  wire logic [7:0]  req_idx_i,    // register index
  input  wire logic [63:0] req_wdata_i,  // write data
  output logic             ready_o,      // request can be taken
  output logic             ack_o,        // answer pulse
  output logic             fault_o,      // protection fault with ack
  output logic      [63:0] rdata_o,      // read data, valid with ack
  output logic             flush_o,      // flush all translation entries
  output logic      [31:0] feature_o,    // feature query result word
  input  wire logic [35:0] addr_i,       // access physical address
  output logic      [7:0]  type_o        // memory type of addr_i
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // reserved type code check
  function automatic logic type_rsvd(input logic [7:0] t);
    type_rsvd = !((t == mrtm_pkg::mt_uncacheable) ||
                  (t == mrtm_pkg::mt_write_combining) ||
                  (t == mrtm_pkg::mt_write_through) ||
                  (t == mrtm_pkg::mt_write_protected) ||
                  (t == mrtm_pkg::mt_writeback));
  endfunction

  // fault check for one write to an array word
  function automatic logic word_bad(input logic [7:0] idx, input logic [63:0] d);
    logic bad;
    bad = 1'b0;
    if (idx == `MRTM_IDX_DEF) begin
      bad = type_rsvd(d[7:0]) || ((d & `MRTM_DEF_RSVD) != '0);
    end else if (idx <= `MRTM_IDX_FIX_HI) begin
      for (int b = 0; b < 8; b++) begin
        bad = bad || type_rsvd(d[8 * b +: 8]);
      end
    end else if (!idx[0]) begin
      bad = type_rsvd(d[7:0]) || ((d & `MRTM_BASE_RSVD) != '0);
    end else begin
      bad = ((d & `MRTM_MASK_RSVD) != '0);
    end
    word_bad = bad;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mrtm_pkg::mrtm_state_t   state_ff, nxt_state;
  mrtm_pkg::mrtm_msr_req_t req;
  logic        ready_ff, nxt_ready;
  logic        ack_ff, nxt_ack;
  logic        fault_ff, nxt_fault;
  logic        flush_ff, nxt_flush;
  logic [63:0] rdata_ff, nxt_rdata;
  logic [31:0] feature_ff;
  logic        take;
  logic        is_cap;
  logic        is_word;
  logic        bad;
  logic        wr_en;
  logic        rd_en;
  logic [63:0] mem_rdata;
  logic [`MRTM_WORDS-1:0][63:0] words;
  logic        fix_hit;

  assign req     = '{wr: req_wr_i, idx: req_idx_i, wdata: req_wdata_i};
  assign take    = req_i && (state_ff == mrtm_pkg::st_idle);
  assign is_cap  = (req.idx == `MRTM_IDX_CAP);
  assign is_word = (req.idx <= `MRTM_LAST_WORD);

  // fault decode: capability write, bad data, unmapped index
  always_comb begin
    bad = !(is_cap || is_word);
    if (req.wr && is_cap) begin
      bad = 1'b1;
    end else if (req.wr && is_word) begin
      bad = word_bad(req.idx, req.wdata);
    end
  end

  assign wr_en = take && req.wr && is_word && !bad;
  assign rd_en = take && !req.wr && is_word;

  // ------------------------------------------------------------
  // access state machine
  // ------------------------------------------------------------

  // answers come one edge after the take; reads of words stall one cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_ack   = 1'b0;
    nxt_fault = 1'b0;
    nxt_flush = 1'b0;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      mrtm_pkg::st_idle: begin
        if (take && rd_en) begin
          nxt_state = mrtm_pkg::st_read;
        end else if (take) begin
          nxt_ack   = 1'b1;
          nxt_fault = bad;
          nxt_flush = wr_en;
          // constant word: eight variable, fixed present, write combining
          if (!req.wr && is_cap) begin
            nxt_rdata = `MRTM_CAP_VALUE;
          end else if (!req.wr) begin
            nxt_rdata = '0;
          end
        end
      end
      mrtm_pkg::st_read: begin
        nxt_state = mrtm_pkg::st_idle;
        nxt_ack   = 1'b1;
        nxt_rdata = mem_rdata;
      end
    endcase
    nxt_ready = (nxt_state == mrtm_pkg::st_idle);
  end

  // registers of the access port
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff   <= mrtm_pkg::st_idle;
      ready_ff   <= 1'b1;
      ack_ff     <= 1'b0;
      fault_ff   <= 1'b0;
      flush_ff   <= 1'b0;
      rdata_ff   <= '0;
      feature_ff <= `MRTM_FEAT_VALUE;
    end else begin
      state_ff   <= nxt_state;
      ready_ff   <= nxt_ready;
      ack_ff     <= nxt_ack;
      fault_ff   <= nxt_fault;
      flush_ff   <= nxt_flush;
      rdata_ff   <= nxt_rdata;
      feature_ff <= `MRTM_FEAT_VALUE;
    end
  end

  // ------------------------------------------------------------
  // storage and lookup
  // ------------------------------------------------------------

  // local copy only; no port exists to share it
  mrtm_regfile u_regfile (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_en),
    .wr_idx_i  (req.idx[4:0]),
    .wr_data_i (req.wdata),
    .rd_en_i   (rd_en),
    .rd_idx_i  (req.idx[4:0]),
    .rd_data_o (mem_rdata),
    .words_o   (words)
  );

  // unregistered so the type meets the access in its own cycle
  mrtm_lookup u_lookup (
    .addr_i    (addr_i),
    .words_i   (words),
    .type_o    (type_o),
    .fix_hit_o (fix_hit)
  );

  // port outputs
  assign ready_o   = ready_ff;
  assign ack_o     = ack_ff;
  assign fault_o   = fault_ff;
  assign rdata_o   = rdata_ff;
  assign flush_o   = flush_ff;
  assign feature_o = feature_ff;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------

  a_cap_read_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && !req.wr && is_cap) |=> (ack_o && !fault_o && rdata_o == `MRTM_CAP_VALUE))
    else $error("capability read did not return its constant");

  a_cap_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && !req.wr && is_cap) |=> (rdata_o[63:11] == '0 && !rdata_o[9] &&
                                     rdata_o[7:0] == 8'h08 && rdata_o[8] && rdata_o[10]))
    else $error("capability fields wrong");

  a_cap_write_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && req.wr && is_cap) |=> (ack_o && fault_o && !flush_o))
    else $error("capability write not faulted");

  a_rsvd_type_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && req.wr && req.idx == `MRTM_IDX_DEF && type_rsvd(req.wdata[7:0]))
      |=> (ack_o && fault_o && words[0] == $past(words[0])))
    else $error("reserved type accepted");

  a_flush_on_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && req.wr && is_word && !bad) |=> (flush_o && ack_o && !fault_o)
      ##1 (flush_o == $past(wr_en)))
    else $error("range write did not flush once");

  a_no_stray_flush: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flush_o |-> ($past(wr_en) && !fault_o))
    else $error("flush without accepted write");

  a_disabled_uc: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !words[0][`MRTM_DEF_E_BIT] |-> (type_o == 8'h00))
    else $error("type not uncacheable while disabled");

  a_reset_uc: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (type_o == 8'h00 && words[0] == '0 && ready_o && !ack_o))
    else $error("ranges not disabled after reset");

  a_fixed_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (words[0][`MRTM_DEF_E_BIT] && words[0][`MRTM_DEF_FE_BIT] && addr_i[35:20] == 16'h0000)
      |-> fix_hit)
    else $error("fixed range not used below 1 MB");

  a_feature_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    feature_o[`MRTM_FEAT_RT_BIT] && $stable(feature_o))
    else $error("feature flag lost");

  a_read_latency: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_en |=> (!ready_o && !ack_o)
      ##1 (ack_o && ready_o && rdata_o == $past(words[req.idx[4:0]], 2)))
    else $error("word read answer wrong");

  // ------------------------------------------------------------
  // access port, lookup and feature word assertions
  // ------------------------------------------------------------

  // a fault is only ever reported as part of an answer
  a_fault_with_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    fault_o |-> ack_o)
    else $error("fault without answer");

  // a refused write leaves every word as it was and flushes nothing
  a_fault_no_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && req.wr && bad) |=> (words == $past(words) && !flush_o))
    else $error("refused write changed a word");

  // an accepted write is visible in the next cycle
  a_write_lands: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en |=> (words[$past(req.idx[4:0])] == $past(req.wdata)))
    else $error("accepted write not stored");

  // everything but a word read answers on the next edge
  a_answer_next: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && !rd_en) |=> (ack_o && ready_o))
    else $error("answer not one cycle after take");

  // a second answer in a row needs a second take
  a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ack_o |=> (!ack_o || $past(take)))
    else $error("answer stretched");

  // no answer without a request behind it
  a_no_idle_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ack_o |-> ($past(take) || $past(state_ff == mrtm_pkg::st_read)))
    else $error("answer without request");

  // read data only move together with an answer
  a_rdata_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ack_o |-> $stable(rdata_o))
    else $error("read data moved without answer");

  // unknown indices are refused whatever the direction
  a_unmapped_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (take && !is_cap && !is_word) |=> (ack_o && fault_o && !flush_o))
    else $error("unmapped index not faulted");

  // fixed fields are ignored while their enable is clear
  a_var_no_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (words[0][`MRTM_DEF_E_BIT] && !words[0][`MRTM_DEF_FE_BIT]) |-> !fix_hit)
    else $error("fixed field used while disabled");

  // fixed fields never reach above the first megabyte
  a_high_no_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (addr_i[35:20] != 16'h0000) |-> !fix_hit)
    else $error("fixed field used above 1 MB");

  // the feature word is the fixed constant
  a_feature_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    feature_o == `MRTM_FEAT_VALUE)
    else $error("feature word wrong");

endmodule

// ===== testbench/mrtm_sw_model.sv
// requester model: privileged software issuing model-register accesses
// assumes: one access at a time, answered by ready/ack of the access port
`timescale 1ns/1ps

module mrtm_sw_model (
  input  wire logic        clk_sys_i,    // core clock
  input  wire logic        ready_i,      // port can take a request
  input  wire logic        ack_i,        // answer pulse
  input  wire logic        fault_i,      // protection fault
  input  wire logic [63:0] rdata_i,      // read data
  input  wire logic        flush_i,      // translation flush pulse
  output logic             req_o,        // access request
  output logic             req_wr_o,     // 1 write, 0 read
  output logic      [7:0]  req_idx_o,    // register index
  output logic      [63:0] req_wdata_o   // write data
);
  // idle qualifiers carry junk so a stale value is never taken for a request
  initial begin
    req_o       = 1'b0;
    req_wr_o    = 1'b0;
    req_idx_o   = 8'hA5;
    req_wdata_o = 64'h5A5A_5A5A_5A5A_5A5A;
  end

  // one access; request held until taken, then wait for the answer
  task automatic access(input logic wr, input logic [7:0] idx, input logic [63:0] wd,
                        output logic flt, output logic fl, output logic [63:0] rd);
    int n;
    @(negedge clk_sys_i);
    req_o       = 1'b1;
    req_wr_o    = wr;
    req_idx_o   = idx;
    req_wdata_o = wd;
    n = 0;
    while (ready_i !== 1'b1 && n < 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    // taken at the rising edge just passed; only now let go
    @(negedge clk_sys_i);
    req_o       = 1'b0;
    req_idx_o   = ~idx;
    req_wdata_o = ~wd;
    n = 0;
    while (ack_i !== 1'b1 && n < 4) begin
      @(negedge clk_sys_i);
      n++;
    end
    // a missing answer leaves fault and flush unknown so their compares fail
    flt = (ack_i === 1'b1) ? fault_i : 1'bx;
    fl  = (ack_i === 1'b1) ? flush_i : 1'bx;
    rd  = rdata_i;
  endtask
endmodule

// ===== testbench/mrtm_top_bench.sv
// self-checking bench of the range type map: register accesses and lookups
// assumes: mrtm_sw_model drives the access port, bench drives the address
`timescale 1ns/1ps

module mrtm_top_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i;
  logic [35:0] addr_i;
  logic        req_i;
  logic        req_wr_i;
  logic [7:0]  req_idx_i;
  logic [63:0] req_wdata_i;
  logic        ready_o;
  logic        ack_o;
  logic        fault_o;
  logic [63:0] rdata_o;
  logic        flush_o;
  logic [31:0] feature_o;
  logic [7:0]  type_o;
  logic        flt;
  logic        fl;
  logic [63:0] rd;
  int          num_errors = 0;
  int          cmp_count = 0;

  // 250 MHz core clock
  always #2 clk_sys_i = ~clk_sys_i;

  mrtm_top dut (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .req_i       (req_i),
    .req_wr_i    (req_wr_i),
    .req_idx_i   (req_idx_i),
    .req_wdata_i (req_wdata_i),
    .ready_o     (ready_o),
    .ack_o       (ack_o),
    .fault_o     (fault_o),
    .rdata_o     (rdata_o),
    .flush_o     (flush_o),
    .feature_o   (feature_o),
    .addr_i      (addr_i),
    .type_o      (type_o)
  );

  mrtm_sw_model sw (
    .clk_sys_i   (clk_sys_i),
    .ready_i     (ready_o),
    .ack_i       (ack_o),
    .fault_i     (fault_o),
    .rdata_i     (rdata_o),
    .flush_i     (flush_o),
    .req_o       (req_i),
    .req_wr_o    (req_wr_i),
    .req_idx_o   (req_idx_i),
    .req_wdata_o (req_wdata_i)
  );

  // ------------------------------------------------------------
  // compare and access helpers
  // ------------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0b seen %0b", name, exp, got);
    end
  endtask

  // a write flushes translations exactly when it is not refused
  task automatic wr(input logic [7:0] idx, input logic [63:0] wd, input logic exp_flt);
    sw.access(1'b1, idx, wd, flt, fl, rd);
    chk_flag("write fault", exp_flt, flt);
    chk_flag("flush", ~exp_flt, fl);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [63:0] exp, input logic exp_flt);
    sw.access(1'b0, idx, 64'h0, flt, fl, rd);
    chk_flag("read fault", exp_flt, flt);
    chk_word("read data", exp, rd);
  endtask

  // lookup is combinational, so look 1 ns after the address moves
  task automatic look(input logic [35:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    addr_i = a;
    #1;
    chk_word("type", {56'h0, exp}, {56'h0, type_o});
  endtask

  // ------------------------------------------------------------
  // watchdog: whole sequence needs well under 2000 cycles
  // ------------------------------------------------------------
  initial begin
    #40000;
    num_errors++;
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    addr_i  = 36'h0;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk_word("feature", 64'h1000, {32'h0, feature_o});
    chk_flag("ready", 1'b1, ready_o);
    look(36'h0_0001_0000, 8'h00);
    rd_chk(8'h00, 64'h0, 1'b0);
    rd_chk(8'h20, 64'h508, 1'b0);
    wr(8'h20, 64'h0, 1'b1);
    rd_chk(8'h20, 64'h508, 1'b0);
    rd_chk(8'h21, 64'h0, 1'b1);
    // every type code into the default word; 06 is the last one kept
    for (int t = 0; t < 256; t++) begin
      wr(8'h00, {56'h0, t[7:0]}, !(t inside {0, 1, 4, 5, 6}));
    end
    look(36'h0_1234_5000, 8'h00);
    wr(8'h00, 64'hC06, 1'b0);
    wr(8'h01, 64'h0605_0401_0006_0504, 1'b0);
    wr(8'h0B, 64'h0400_0000_0000_0000, 1'b0);
    wr(8'h0C, 64'h1, 1'b0);
    wr(8'h0D, 64'hF_F000_0800, 1'b0);
    wr(8'h0C, 64'h7, 1'b1);
    rd_chk(8'h0C, 64'h1, 1'b0);
    look(36'h0_0001_0000, 8'h05);
    look(36'h0_0003_0000, 8'h00);
    look(36'h0_000F_F000, 8'h04);
    look(36'h0_0020_0000, 8'h01);
    look(36'h0_1000_0000, 8'h06);
    wr(8'h00, 64'h806, 1'b0);
    look(36'h0_0003_0000, 8'h01);
    wr(8'h00, 64'h006, 1'b0);
    look(36'h0_0020_0000, 8'h00);
    // programmed map must be wiped by a reset in mid-run
    wr(8'h00, 64'hC06, 1'b0);
    look(36'h0_0002_0000, 8'h06);
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk_flag("ready", 1'b1, ready_o);
    look(36'h0_0002_0000, 8'h00);
    rd_chk(8'h01, 64'h0, 1'b0);
    rd_chk(8'h0D, 64'h0, 1'b0);
    close_out();
  end
endmodule
